// ===== logic/cyclic_timer.sv
// One cyclic timer: on-time window inside a repeating period.
// Assumes a shared tick pulse every 0.1 ms from the parent.
`timescale 1ns/1ps
module cyclic_timer (
  input wire logic clock,
  input wire logic resetn,
  input wire logic tick,
  input wire wake_timer_pkg::timer_cfg_t cfg,
  output logic window,
  output logic window_end,
  output logic switch_out
);
  import wake_timer_pkg::*;

  logic [14:0] count_q, count_d;
  logic window_q, window_d;
  logic end_q, end_d;
  logic out_q, out_d;
  logic running;
  logic [14:0] on_len, per_len;

  always_comb begin
    on_len = 15'h0;
    per_len = 15'h0;
    unique case (cfg.on_time)
      3'h1: on_len = 15'(ON_T1);
      3'h2: on_len = 15'(ON_T2);
      3'h3: on_len = 15'(ON_T3);
      3'h4: on_len = 15'(ON_T4);
      3'h5: on_len = 15'(ON_T5);
      default: on_len = 15'h0;
    endcase
    unique case (cfg.period)
      3'h0: per_len = 15'(PER_T0);
      3'h1: per_len = 15'(PER_T1);
      3'h2: per_len = 15'(PER_T2);
      3'h3: per_len = 15'(PER_T3);
      3'h4: per_len = 15'(PER_T4);
      3'h5: per_len = 15'(PER_T5);
      3'h6: per_len = 15'(PER_T6);
      default: per_len = 15'h0;
    endcase
  end

  // Runs while a running on-time code and a non-reserved period code are present
  assign running = (on_len != 15'h0) && (cfg.period != PER_RESERVED);

  always_comb begin
    count_d = count_q;
    window_d = window_q;
    end_d = 1'b0;
    if (!running) begin
      count_d = 15'h0;
      window_d = 1'b0;
    end else if (tick) begin
      if (count_q + 15'h1 >= per_len) begin
        count_d = 15'h0;
        window_d = 1'b1;
      end else begin
        count_d = count_q + 15'h1;
        if (count_q + 15'h1 == on_len) begin
          window_d = 1'b0;
          end_d = window_q;
        end
      end
    end
    if (running && count_q == 15'h0 && !window_q && !tick) begin
      window_d = 1'b1;
    end
    // Static high code drives switch high, off codes low
    out_d = (cfg.on_time == ON_OFF_HIGH) ? 1'b1 : (running & window_d);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_q <= 15'h0;
      window_q <= 1'b0;
      end_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      count_q <= count_d;
      window_q <= window_d;
      end_q <= end_d;
      out_q <= out_d;
    end
  end

  assign window = window_q;
  assign window_end = end_q;
  assign switch_out = out_q;

  a_stop_low: assert property (@(posedge clock) disable iff (!resetn)
    (cfg.on_time == ON_OFF_LOW) |=> !switch_out) else $error("switch high while stopped low");
  a_stop_high: assert property (@(posedge clock) disable iff (!resetn)
    (cfg.on_time == ON_OFF_HIGH) |=> switch_out && !window) else $error("static high wrong");
  a_reserved_quiet: assert property (@(posedge clock) disable iff (!resetn)
    (cfg.on_time == ON_RESERVED || cfg.period == PER_RESERVED) |=> !window && !window_end)
    else $error("reserved code produced window");
endmodule

// ===== logic/wake_filter_cyclic_timers.sv
// Wake filter settings and two cyclic timers with their register set.
// Assumes the serial control interface delivers one-cycle register requests.
//
// What this block does
// - Filter code 00: static, 16 us filter
// - Filter code 01: static, 64 us filter
// - Code 10: cyclic, sample at first timer end
// - Code 11: cyclic, sample at second timer end
// - Filter fields at 5:4, 3:2, 1:0, reset zero
// - On-time 000 stops, low; 001 to 101 set on-times
// - On-time 110 stops, output high; 111 reserved
// - Period codes select 10 ms to 2 s
// - On-time bits 6:4, period 2:0, both timers
// - Timer starts when running on-time and non-reserved period written
// - Restart switch clear also clears fields of timers with sense used
// - Cyclic wake and sense share timer concurrently
// - Reserved bits always read zero
// - Timer wake enables select cyclic wake source
`timescale 1ns/1ps
module wake_filter_cyclic_timers (
  input wire logic clock,
  input wire logic resetn,
  input wire wake_timer_pkg::reg_req_t req,
  input wire logic req_valid,
  output logic [7:0] rdata,
  input wire logic wake_in_a,
  input wire logic wake_in_b,
  input wire logic wake_in_c,
  input wire logic first_timer_wake_enable,
  input wire logic second_timer_wake_enable,
  input wire logic first_timer_sense_used,
  input wire logic second_timer_sense_used,
  input wire logic restart_switch_clear,
  output logic [2:0] wake_level,
  output logic first_timer_switch,
  output logic second_timer_switch,
  output logic first_timer_wake,
  output logic second_timer_wake
);
  import wake_timer_pkg::*;

  logic [7:0] filter_q, filter_d;
  timer_cfg_t first_q, first_d, second_q, second_d;
  logic [7:0] rdata_q, rdata_d;
  logic [15:0] tick_cnt_q, tick_cnt_d;
  logic tick;
  logic first_win, first_end, second_win, second_end;
  logic first_wake_q, first_wake_d, second_wake_q, second_wake_d;
  logic [2:0] pins;
  logic [1:0] sel [3];

  // Register writes, reads and restart clearing
  always_comb begin
    filter_d = filter_q;
    first_d = first_q;
    second_d = second_q;
    rdata_d = rdata_q;
    if (req_valid && req.write) begin
      unique case (req.addr)
        WAKE_FILTER_CONFIG_ADDR: filter_d = req.wdata & FILTER_MASK;
        FIRST_TIMER_CONFIG_ADDR: begin
          first_d.on_time = req.wdata[ON_TIME_LSB +: 3];
          first_d.period = req.wdata[PERIOD_LSB +: 3];
        end
        SECOND_TIMER_CONFIG_ADDR: begin
          second_d.on_time = req.wdata[ON_TIME_LSB +: 3];
          second_d.period = req.wdata[PERIOD_LSB +: 3];
        end
        default: ;
      endcase
    end
    if (restart_switch_clear && first_timer_sense_used) begin
      first_d = '0;
    end
    if (restart_switch_clear && second_timer_sense_used) begin
      second_d = '0;
    end
    if (req_valid && !req.write) begin
      unique case (req.addr)
        WAKE_FILTER_CONFIG_ADDR: rdata_d = filter_q & FILTER_MASK;
        FIRST_TIMER_CONFIG_ADDR: rdata_d = {1'b0, first_q.on_time, 1'b0, first_q.period};
        SECOND_TIMER_CONFIG_ADDR: rdata_d = {1'b0, second_q.on_time, 1'b0, second_q.period};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      filter_q <= REG_RESET;
      first_q <= '0;
      second_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      filter_q <= filter_d;
      first_q <= first_d;
      second_q <= second_d;
      rdata_q <= rdata_d;
    end
  end

  // Shared 0.1 ms time base
  always_comb begin
    tick = (tick_cnt_q == 16'(TICK_CYC - 1));
    tick_cnt_d = tick ? 16'h0 : tick_cnt_q + 16'h1;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 16'h0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  cyclic_timer first_timer (
    .clock(clock),
    .resetn(resetn),
    .tick(tick),
    .cfg(first_q),
    .window(first_win),
    .window_end(first_end),
    .switch_out(first_timer_switch)
  );

  cyclic_timer second_timer (
    .clock(clock),
    .resetn(resetn),
    .tick(tick),
    .cfg(second_q),
    .window(second_win),
    .window_end(second_end),
    .switch_out(second_timer_switch)
  );

  // One filter per wake input
  assign pins = {wake_in_c, wake_in_b, wake_in_a};
  assign sel[0] = filter_q[FILTER_A_LSB +: 2];
  assign sel[1] = filter_q[FILTER_B_LSB +: 2];
  assign sel[2] = filter_q[FILTER_C_LSB +: 2];

  for (genvar i = 0; i < 3; i++) begin : g_filter
    wake_input_filter filt (
      .clock(clock),
      .resetn(resetn),
      .pin(pins[i]),
      .sel(sel[i]),
      .first_window(first_win),
      .first_end(first_end),
      .second_window(second_win),
      .second_end(second_end),
      .level(wake_level[i])
    );
  end

  // Cyclic wake pulses, independent of cyclic sense use
  always_comb begin
    first_wake_d = first_timer_wake_enable & first_end;
    second_wake_d = second_timer_wake_enable & second_end;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      first_wake_q <= 1'b0;
      second_wake_q <= 1'b0;
    end else begin
      first_wake_q <= first_wake_d;
      second_wake_q <= second_wake_d;
    end
  end

  assign first_timer_wake = first_wake_q;
  assign second_timer_wake = second_wake_q;
  assign rdata = rdata_q;

  a_filter_write: assert property (@(posedge clock) disable iff (!resetn)
    (req_valid && req.write && req.addr == WAKE_FILTER_CONFIG_ADDR)
    |=> filter_q == ($past(req.wdata) & FILTER_MASK)) else $error("filter write lost");
  a_timer_fields: assert property (@(posedge clock) disable iff (!resetn)
    (req_valid && req.write && req.addr == FIRST_TIMER_CONFIG_ADDR && !restart_switch_clear)
    |=> first_q.on_time == $past(req.wdata[6:4]) && first_q.period == $past(req.wdata[2:0]))
    else $error("timer write lost");
  a_reserved_zero: assert property (@(posedge clock) disable iff (!resetn)
    (req_valid && !req.write && req.addr == FIRST_TIMER_CONFIG_ADDR) |=> rdata[7] == 1'b0 && rdata[3] == 1'b0)
    else $error("reserved bits set");
  a_restart_clear: assert property (@(posedge clock) disable iff (!resetn)
    (restart_switch_clear && second_timer_sense_used) |=> second_q == '0) else $error("timer not cleared");
  a_wake_pulse: assert property (@(posedge clock) disable iff (!resetn)
    (first_end && first_timer_wake_enable) |=> first_timer_wake) else $error("cyclic wake missed");
endmodule

// ===== logic/wake_input_filter.sv
// Wake input filter: static debounce or cyclic sampling at a timer window end.
// Pin input is synchronised here with two flip-flops.
`timescale 1ns/1ps
module wake_input_filter (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pin,
  input wire logic [1:0] sel,
  input wire logic first_window,
  input wire logic first_end,
  input wire logic second_window,
  input wire logic second_end,
  output logic level
);
  import wake_timer_pkg::*;

  logic sync1_q, sync2_q;
  logic [13:0] cnt_q, cnt_d;
  logic level_q, level_d;
  logic [13:0] limit;
  logic cyclic, win, win_end;

  always_comb begin
    cyclic = sel[1];
    win = (sel == FLT_CYCLIC_FIRST) ? first_window : second_window;
    win_end = (sel == FLT_CYCLIC_FIRST) ? first_end : second_end;
    limit = (sel == FLT_STATIC_LONG) ? 14'(FILTER_LONG_CYC) : 14'(FILTER_SHORT_CYC);
    cnt_d = cnt_q;
    level_d = level_q;
    if (cyclic && !win) begin
      cnt_d = 14'h0;
    end else if (sync2_q == level_q) begin
      cnt_d = 14'h0;
    end else if (cnt_q + 14'h1 < limit) begin
      cnt_d = cnt_q + 14'h1;
    end else if (!cyclic) begin
      cnt_d = 14'h0;
      level_d = sync2_q;
    end else begin
      cnt_d = cnt_q;
    end
    // Cyclic: accept only if stable for the filter time at window end
    if (cyclic && win_end) begin
      cnt_d = 14'h0;
      if (sync2_q != level_q && cnt_q + 14'h1 >= limit) begin
        level_d = sync2_q;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      cnt_q <= 14'h0;
      level_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      cnt_q <= cnt_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;

  a_cyclic_hold: assert property (@(posedge clock) disable iff (!resetn)
    (cyclic && !win_end) |=> $stable(level)) else $error("cyclic level changed off window end");
endmodule

// ===== logic/wake_timer_pkg.sv
// Package for the wake filter and cyclic timer block: register map, fields, timing.
// Assumes a 250 MHz core clock; filter times and the tick converted to cycles here, on-times and periods kept in ticks.
package wake_timer_pkg;
  localparam int unsigned CLOCK_HZ = 250_000_000;
  localparam int unsigned CLOCK_MHZ = CLOCK_HZ / 1_000_000;

  // Register addresses on the serial control interface (7-bit address)
  localparam logic [6:0] WAKE_FILTER_CONFIG_ADDR = 7'h09;
  localparam logic [6:0] FIRST_TIMER_CONFIG_ADDR = 7'h0c;
  localparam logic [6:0] SECOND_TIMER_CONFIG_ADDR = 7'h0d;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions
  localparam int FILTER_A_LSB = 0;
  localparam int FILTER_B_LSB = 2;
  localparam int FILTER_C_LSB = 4;
  localparam logic [7:0] FILTER_MASK = 8'h3f;
  localparam int ON_TIME_LSB = 4;
  localparam int PERIOD_LSB = 0;
  localparam logic [7:0] TIMER_MASK = 8'h77;

  // Filter selections
  localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
  localparam logic [1:0] FLT_CYCLIC_FIRST = 2'h2;
  localparam logic [1:0] FLT_CYCLIC_SECOND = 2'h3;

  // On-time and period codes
  localparam logic [2:0] ON_OFF_LOW = 3'h0;
  localparam logic [2:0] ON_OFF_HIGH = 3'h6;
  localparam logic [2:0] ON_RESERVED = 3'h7;
  localparam logic [2:0] PER_RESERVED = 3'h7;

  // Filter times in microseconds and cycles
  localparam int unsigned FILTER_SHORT_US = 16;
  localparam int unsigned FILTER_LONG_US = 64;
  localparam int unsigned FILTER_SHORT_CYC = FILTER_SHORT_US * CLOCK_MHZ;
  localparam int unsigned FILTER_LONG_CYC = FILTER_LONG_US * CLOCK_MHZ;

  // Timer base tick: 0.1 ms, all on-times and periods are multiples of it
  localparam int unsigned TICK_US = 100;
  localparam int unsigned TICK_CYC = TICK_US * CLOCK_MHZ;
  // On-times in ticks: 0.1, 0.3, 1.0, 10, 20 ms
  localparam int unsigned ON_T1 = 1;
  localparam int unsigned ON_T2 = 3;
  localparam int unsigned ON_T3 = 10;
  localparam int unsigned ON_T4 = 100;
  localparam int unsigned ON_T5 = 200;
  // Periods in ticks: 10, 20, 50, 100, 200 ms, 1 s, 2 s
  localparam int unsigned PER_T0 = 100;
  localparam int unsigned PER_T1 = 200;
  localparam int unsigned PER_T2 = 500;
  localparam int unsigned PER_T3 = 1000;
  localparam int unsigned PER_T4 = 2000;
  localparam int unsigned PER_T5 = 10000;
  localparam int unsigned PER_T6 = 20000;

  typedef struct packed {
    logic [2:0] on_time;
    logic [2:0] period;
  } timer_cfg_t;

  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// ===== verification/tb_top.sv
// Self-checking bench for the wake filter and cyclic timer block.
// Assumes the package timing at 250 MHz; the bench drives every port itself.
`timescale 1ns/1ps
module tb_top;
  import wake_timer_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  reg_req_t req = '0;
  logic req_valid = 1'b0;
  logic [7:0] rdata;
  logic wake_in_a = 1'b0;
  logic wake_in_b = 1'b0;
  logic wake_in_c = 1'b0;
  logic first_timer_wake_enable = 1'b0;
  logic second_timer_wake_enable = 1'b0;
  logic first_timer_sense_used = 1'b0;
  logic second_timer_sense_used = 1'b0;
  logic restart_switch_clear = 1'b0;
  logic [2:0] wake_level;
  logic first_timer_switch;
  logic second_timer_switch;
  logic first_timer_wake;
  logic second_timer_wake;
  int errors = 0;
  int n_compared = 0;
  int wake1_cnt = 0;
  int wake2_cnt = 0;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;

  always #2 clock = ~clock;

  wake_filter_cyclic_timers i_wake_filter_cyclic_timers (
    .clock(clock),
    .resetn(resetn),
    .req(req),
    .req_valid(req_valid),
    .rdata(rdata),
    .wake_in_a(wake_in_a),
    .wake_in_b(wake_in_b),
    .wake_in_c(wake_in_c),
    .first_timer_wake_enable(first_timer_wake_enable),
    .second_timer_wake_enable(second_timer_wake_enable),
    .first_timer_sense_used(first_timer_sense_used),
    .second_timer_sense_used(second_timer_sense_used),
    .restart_switch_clear(restart_switch_clear),
    .wake_level(wake_level),
    .first_timer_switch(first_timer_switch),
    .second_timer_switch(second_timer_switch),
    .first_timer_wake(first_timer_wake),
    .second_timer_wake(second_timer_wake)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One register request; a read leaves its expected value for the monitor
  task automatic bus(input logic wr, input logic [6:0] addr, input logic [7:0] data, input logic [7:0] exp);
    @(posedge clock);
    req <= '{write: wr, addr: addr, wdata: data};
    req_valid <= 1'b1;
    if (!wr) exp_q.push_back(exp);
    @(posedge clock);
    req_valid <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Bounded wait for a timer switch output to reach a level
  task automatic wait_sw(input logic second, input logic lvl, input int lim);
    int k;
    k = 0;
    while (((second ? second_timer_switch : first_timer_switch) !== lvl) && k < lim) begin
      @(posedge clock);
      #1;
      k++;
    end
    check("switch level reached", 8'(k < lim), 8'h01);
  endtask

  // Read data answers one cycle after the request is taken
  always @(posedge clock) begin
    if (rd_pend && exp_q.size() > 0) check("rdata", rdata, exp_q.pop_front());
    rd_pend <= req_valid && !req.write;
    if (first_timer_wake === 1'b1) wake1_cnt <= wake1_cnt + 1;
    if (second_timer_wake === 1'b1) wake2_cnt <= wake2_cnt + 1;
  end

  initial begin
    repeat (95000) @(posedge clock);
    errors++;
    tally_and_finish();
  end

  initial begin
    logic [7:0] d;
    void'($urandom(14));
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    // Timers are assigned to switches before any on-time is written
    first_timer_sense_used <= 1'b1;
    second_timer_sense_used <= 1'b1;
    bus(1'b0, WAKE_FILTER_CONFIG_ADDR, 8'h00, REG_RESET);
    bus(1'b0, FIRST_TIMER_CONFIG_ADDR, 8'h00, REG_RESET);
    bus(1'b0, SECOND_TIMER_CONFIG_ADDR, 8'h00, REG_RESET);
    $display("test reset_values done");

    for (int k = 0; k < 8; k++) begin
      d = {1'b1, k[2:0], 1'b1, k[2:0]};
      bus(1'b1, FIRST_TIMER_CONFIG_ADDR, d, 8'h00);
      bus(1'b1, SECOND_TIMER_CONFIG_ADDR, d, 8'h00);
      bus(1'b0, FIRST_TIMER_CONFIG_ADDR, 8'h00, d & TIMER_MASK);
      bus(1'b0, SECOND_TIMER_CONFIG_ADDR, 8'h00, d & TIMER_MASK);
      cyc(3);
      check("first switch", 8'(first_timer_switch), 8'(k >= 1 && k <= 6));
      check("second switch", 8'(second_timer_switch), 8'(k >= 1 && k <= 6));
    end
    bus(1'b1, FIRST_TIMER_CONFIG_ADDR, 8'h17, 8'h00);
    cyc(3);
    check("reserved period switch", 8'(first_timer_switch), 8'h00);
    bus(1'b1, FIRST_TIMER_CONFIG_ADDR, 8'h00, 8'h00);
    bus(1'b1, SECOND_TIMER_CONFIG_ADDR, 8'h00, 8'h00);
    cyc(3);
    check("stopped switch", 8'(first_timer_switch), 8'h00);
    $display("test timer_codes done");

    repeat (4) begin
      d = 8'($urandom);
      bus(1'b1, WAKE_FILTER_CONFIG_ADDR, d, 8'h00);
      bus(1'b0, WAKE_FILTER_CONFIG_ADDR, 8'h00, d & FILTER_MASK);
    end
    bus(1'b1, 7'h0a, 8'hff, 8'h00);
    bus(1'b0, 7'h0a, 8'h00, 8'h00);
    bus(1'b0, WAKE_FILTER_CONFIG_ADDR, 8'h00, d & FILTER_MASK);
    $display("test filter_register done");

    // Input a static short, b static long, c static short
    bus(1'b1, WAKE_FILTER_CONFIG_ADDR, 8'h04, 8'h00);
    @(posedge clock);
    wake_in_a <= 1'b1;
    wake_in_b <= 1'b1;
    cyc(int'(FILTER_SHORT_CYC) - 100);
    check("level a early", 8'(wake_level[0]), 8'h00);
    cyc(200);
    check("level a", 8'(wake_level[0]), 8'h01);
    cyc(int'(FILTER_LONG_CYC - FILTER_SHORT_CYC) - 200);
    check("level b early", 8'(wake_level[1]), 8'h00);
    cyc(200);
    check("level b", 8'(wake_level[1]), 8'h01);
    $display("test static_filters done");

    // Input a sampled by the second timer, c by the first
    bus(1'b1, WAKE_FILTER_CONFIG_ADDR, 8'h23, 8'h00);
    @(posedge clock);
    wake_in_a <= 1'b0;
    wake_in_c <= 1'b1;
    first_timer_wake_enable <= 1'b1;
    bus(1'b1, FIRST_TIMER_CONFIG_ADDR, 8'h10, 8'h00);
    wait_sw(1'b0, 1'b1, 4);
    cyc(50);
    check("levels in window", 8'(wake_level), 8'h03);
    wait_sw(1'b0, 1'b0, int'(TICK_CYC * ON_T1) + 10);
    cyc(5);
    check("levels after first", 8'(wake_level), 8'h07);
    check("first wake pulses", 8'(wake1_cnt), 8'h01);
    bus(1'b1, SECOND_TIMER_CONFIG_ADDR, 8'h10, 8'h00);
    wait_sw(1'b1, 1'b1, 4);
    wait_sw(1'b1, 1'b0, int'(TICK_CYC * ON_T1) + 10);
    cyc(5);
    check("levels after second", 8'(wake_level), 8'h06);
    check("second wake pulses", 8'(wake2_cnt), 8'h00);
    $display("test cyclic_sensing done");

    @(posedge clock);
    second_timer_sense_used <= 1'b0;
    restart_switch_clear <= 1'b1;
    @(posedge clock);
    restart_switch_clear <= 1'b0;
    bus(1'b0, FIRST_TIMER_CONFIG_ADDR, 8'h00, 8'h00);
    bus(1'b0, SECOND_TIMER_CONFIG_ADDR, 8'h00, 8'h10);
    cyc(3);
    check("switch after restart clear", 8'(first_timer_switch), 8'h00);
    $display("test restart_clear done");
    tally_and_finish();
  end
endmodule
